// File: eeprom_front_end_consts.svh
// Constants for the serial EEPROM slave front end
`ifndef EEPROM_FRONT_END_CONSTS_SVH
`define EEPROM_FRONT_END_CONSTS_SVH
`define TYPE_ID 4'hA
`define CHIP_ENABLE 3'h1
`define BIT_CNT_W 4
`define ACK_SLOT 4'h8
`define DATA_LAST_BIT 4'h7
`define CLK_MHZ 25
`define INTERNAL_WRITE_TIME_US 5000
`define INTERNAL_WRITE_CYCLES (`INTERNAL_WRITE_TIME_US * `CLK_MHZ)
`define ADDR_W 16
`define ADDR_RESET 16'h0000
`endif

// File: eeprom_front_end_pkg.sv
// Types shared by the serial EEPROM slave front end
package eeprom_front_end_pkg;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SELECT,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA,
    PH_READ
  } phase_e;
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_event_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } write_req_s;
endpackage

// File: line_sync.sv
// Three-flop synchroniser with agreement filter
`timescale 1ns/1ns
module line_sync
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change accepted only once second and third stages agree
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule // line_sync

// File: eeprom_front_end.sv
// Two-wire slave front end of a serial EEPROM, write path
`timescale 1ns/1ns
`include "eeprom_front_end_consts.svh"
module eeprom_front_end
  import eeprom_front_end_pkg::*;
#(
  parameter int WRITE_CYCLES = `INTERNAL_WRITE_CYCLES
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic WRITE_BUSY,
  output logic STANDBY,
  output logic WR_STROBE,
  output logic [15:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic [15:0] ADDR_COUNTER,
  output logic READ_SELECTED
);
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  bus_event_s ev;
  phase_e phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_drive_reg;
  logic ack_pending_reg;
  logic data_acked_reg;
  logic data_byte_reg;
  logic [15:0] addr_reg;
  write_req_s req_reg;
  logic [15:0] last_addr_reg;
  logic [31:0] busy_cnt_reg;
  logic busy_reg;
  logic rd_nack_reg;

  function automatic logic select_match(input logic [7:0] b);
    select_match = (b[7:4] == `TYPE_ID) && (b[3:1] == `CHIP_ENABLE);
  endfunction

  line_sync u_scl
  (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(SCL),
    .dout(scl_s)
  );

  line_sync u_sda
  (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(SDA_IN),
    .dout(sda_s)
  );

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Both conditions require clock high before and after the data edge
  always_comb
  begin
    ev.start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    ev.stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    ev.rise = scl_s && !scl_d_reg;
    ev.fall = !scl_s && scl_d_reg;
  end

  // Protocol sequencer; all state cleared by power-on reset
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_pending_reg <= 1'b0;
      data_acked_reg <= 1'b0;
      addr_reg <= `ADDR_RESET;
      req_reg <= '0;
      data_byte_reg <= 1'b0;
      rd_nack_reg <= 1'b0;
      READ_SELECTED <= 1'b0;
    end
    else if (busy_reg)
    begin
      // Bus isolated: Starts and clocks are not watched
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_pending_reg <= 1'b0;
      data_acked_reg <= 1'b0;
      if (busy_cnt_reg == 32'h1)
        addr_reg <= last_addr_reg + 16'h0001;
    end
    else if (ev.start)
    begin
      phase_reg <= PH_SELECT;
      data_byte_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      ack_pending_reg <= 1'b0;
      data_acked_reg <= 1'b0;
      rd_nack_reg <= 1'b0;
      READ_SELECTED <= 1'b0;
    end
    else if (ev.stop)
    begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_pending_reg <= 1'b0;
      data_acked_reg <= 1'b0;
      READ_SELECTED <= 1'b0;
    end
    else if (ev.rise && phase_reg != PH_IDLE)
    begin
      if (bit_cnt_reg == `ACK_SLOT)
      begin
        bit_cnt_reg <= 4'h0;
        if (phase_reg == PH_READ && sda_s)
        begin
          rd_nack_reg <= 1'b1;
          phase_reg <= PH_IDLE;
        end
        // Tenth slot opens only after a data byte was acknowledged
        // The low address byte also ends in PH_DATA, so a data byte must be seen
        data_acked_reg <= (phase_reg == PH_DATA) && ack_pending_reg &&
          data_byte_reg;
        data_byte_reg <= 1'b0;
        ack_pending_reg <= 1'b0;
      end
      else
      begin
        // The Stop's own clock rise opens the tenth slot; keep the flag
        if (bit_cnt_reg != 4'h0)
          data_acked_reg <= 1'b0;
        shift_reg <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `DATA_LAST_BIT)
        begin
          ack_pending_reg <= 1'b1;
          unique case (phase_reg)
            PH_SELECT:
            begin
              if (select_match({shift_reg[6:0], 1'b0}))
              begin
                if (sda_s)
                begin
                  phase_reg <= PH_READ;
                  READ_SELECTED <= 1'b1;
                end
                else
                  phase_reg <= PH_ADDR_HI;
              end
              else
              begin
                phase_reg <= PH_IDLE;
                ack_pending_reg <= 1'b0;
              end
            end
            PH_ADDR_HI:
            begin
              addr_reg[15:8] <= {shift_reg[6:0], sda_s};
              phase_reg <= PH_ADDR_LO;
            end
            PH_ADDR_LO:
            begin
              addr_reg[7:0] <= {shift_reg[6:0], sda_s};
              phase_reg <= PH_DATA;
            end
            PH_DATA:
            begin
              req_reg.addr <= addr_reg;
              req_reg.data <= {shift_reg[6:0], sda_s};
              data_byte_reg <= 1'b1;
              addr_reg <= addr_reg + 16'h0001;
            end
            PH_READ:
            begin
              ack_pending_reg <= 1'b0;
            end
            PH_IDLE:
            begin
              ack_pending_reg <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Acknowledge drive: set on the fall after bit eight, held for pulse nine
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ack_drive_reg <= 1'b0;
    else if (busy_reg || ev.start || ev.stop)
      ack_drive_reg <= 1'b0;
    else if (ev.fall)
      ack_drive_reg <= ack_pending_reg && bit_cnt_reg == `ACK_SLOT;
  end

  // Internal write timer; only a Stop in the tenth slot starts it
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= 32'h0;
      last_addr_reg <= `ADDR_RESET;
      WR_STROBE <= 1'b0;
      WR_ADDR <= 16'h0000;
      WR_DATA <= 8'h00;
    end
    else
    begin
      WR_STROBE <= 1'b0;
      if (busy_reg)
      begin
        busy_cnt_reg <= busy_cnt_reg - 32'h1;
        if (busy_cnt_reg == 32'h1)
          busy_reg <= 1'b0;
      end
      else if (ev.stop && data_acked_reg && bit_cnt_reg == 4'h1)
      begin
        busy_reg <= 1'b1;
        busy_cnt_reg <= 32'(WRITE_CYCLES);
        last_addr_reg <= req_reg.addr;
        WR_STROBE <= 1'b1;
        WR_ADDR <= req_reg.addr;
        WR_DATA <= req_reg.data;
      end
    end
  end

  // Outputs registered; open drain only ever pulls low
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      WRITE_BUSY <= 1'b0;
      STANDBY <= 1'b1;
      ADDR_COUNTER <= `ADDR_RESET;
    end
    else
    begin
      SDA_OUT <= 1'b0;
      SDA_OE <= ack_drive_reg && !busy_reg;
      WRITE_BUSY <= busy_reg;
      STANDBY <= phase_reg == PH_IDLE && !busy_reg;
      ADDR_COUNTER <= addr_reg;
    end
  end
endmodule // eeprom_front_end

// File: eeprom_front_end_properties.sv
// Port checks for the EEPROM slave front end
`timescale 1ns/1ns
module eeprom_front_end_properties
#(
  parameter int WRITE_CYCLES = 125000
)
(
  input logic CLK,
  input logic ARST_N,
  input logic SCL,
  input logic SDA_IN,
  input logic SDA_OUT,
  input logic SDA_OE,
  input logic WRITE_BUSY,
  input logic STANDBY,
  input logic WR_STROBE,
  input logic [15:0] WR_ADDR,
  input logic [7:0] WR_DATA,
  input logic [15:0] ADDR_COUNTER,
  input logic READ_SELECTED
);
  int busy_n;
  // Write time is far too long for a repetition
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      busy_n <= 0;
    else
      busy_n <= WRITE_BUSY ? busy_n + 1 : 0;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_ack_low; SDA_OE |-> !SDA_OUT; endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("ack not low");
  property p_ack_edge; $changed(SDA_OE) |-> !SCL; endproperty
  a_ack_edge: assert property (p_ack_edge)
    else $error("ack moved with clock high");
  property p_quiet; WRITE_BUSY |-> !SDA_OE; endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer while busy");
  property p_sby; WRITE_BUSY |-> !STANDBY; endproperty
  a_sby: assert property (p_sby)
    else $error("standby while busy");
  property p_go; WR_STROBE |-> ##[0:3] WRITE_BUSY; endproperty
  a_go: assert property (p_go)
    else $error("strobe without busy");
  property p_one; WR_STROBE |=> !WR_STROBE; endproperty
  a_one: assert property (p_one)
    else $error("strobe too long");
  property p_len;
    $fell(WRITE_BUSY) |->
      busy_n >= WRITE_CYCLES - 1 && busy_n <= WRITE_CYCLES + 1;
  endproperty
  a_len: assert property (p_len)
    else $error("write time wrong");
  property p_next;
    $fell(WRITE_BUSY) |-> ##[0:2] ADDR_COUNTER == WR_ADDR + 16'h0001;
  endproperty
  a_next: assert property (p_next)
    else $error("counter not past last byte");
  property p_rd; READ_SELECTED |-> !WRITE_BUSY; endproperty
  a_rd: assert property (p_rd)
    else $error("selected while busy");
endmodule // eeprom_front_end_properties
bind eeprom_front_end eeprom_front_end_properties #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_props (
  .CLK(CLK), .ARST_N(ARST_N), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WRITE_BUSY(WRITE_BUSY),
  .STANDBY(STANDBY), .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR),
  .WR_DATA(WR_DATA), .ADDR_COUNTER(ADDR_COUNTER),
  .READ_SELECTED(READ_SELECTED)
);

// File: i2c_master_model.sv
// Bus master model clocked by its own link clock
`timescale 1ns/1ns
module i2c_master_model
(
  input logic lclk,
  input logic sda,
  output logic scl,
  output logic sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  task automatic h();
    repeat (8) @(posedge lclk);
  endtask
  // Data moves a third of a bit after clock fall, never beside it
  task automatic bitx(input logic v);
    sda_low <= v;
    h();
    scl <= 1'b1;
    h();
    scl <= 1'b0;
    h();
  endtask
  task automatic start();
    sda_low <= 1'b1;
    h();
    scl <= 1'b0;
    h();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    h();
    scl <= 1'b1;
    h();
    sda_low <= 1'b0;
    h();
  endtask
  task automatic wbyte(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b1;
    for (int i = 7; i > 7 - n; i--)
      bitx(!b[i]);
    if (n == 8)
    begin
      sda_low <= 1'b0;
      h();
      scl <= 1'b1;
      h();
      ack = sda;
      scl <= 1'b0;
      h();
    end
  endtask
endmodule // i2c_master_model

// File: tb_top.sv
// Self-checking bench for the EEPROM slave front end
`timescale 1ns/1ns
`include "eeprom_front_end_consts.svh"
module tb_top;
  logic CLK = 1'b0, ARST_N = 1'b0, lclk = 1'b0, scl, m_low, sda, ack;
  logic SDA_OUT, SDA_OE, WRITE_BUSY, STANDBY, WR_STROBE, READ_SELECTED;
  logic [15:0] WR_ADDR, ADDR_COUNTER, a;
  logic [7:0] WR_DATA, d;
  logic [23:0] q[$];
  int num_errors = 0, tests_run = 0, cyc = 0, seed = 32'h050A59C1;
  always #20 CLK = ~CLK;
  initial #7 forever #24 lclk = ~lclk;
  assign sda = !(m_low || (SDA_OE && !SDA_OUT));
  i2c_master_model u_m (.lclk(lclk), .sda(sda), .scl(scl), .sda_low(m_low));
  eeprom_front_end #(.WRITE_CYCLES(2000)) u_dut (.CLK(CLK),
    .ARST_N(ARST_N), .SCL(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .WRITE_BUSY(WRITE_BUSY), .STANDBY(STANDBY),
    .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
    .ADDR_COUNTER(ADDR_COUNTER), .READ_SELECTED(READ_SELECTED));
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic sel(input logic [7:0] b, input logic e);
    u_m.start();
    u_m.wbyte(b, 8, ack);
    chk(ack, e);
  endtask
  // n data bytes, the last cut after k bits
  task automatic wr(input int n, input int k);
    a = $random(seed);
    sel({`TYPE_ID, `CHIP_ENABLE, 1'b0}, 1'b0);
    u_m.wbyte(a[15:8], 8, ack);
    chk(ack, 1'b0);
    u_m.wbyte(a[7:0], 8, ack);
    chk(ack, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      d = $random(seed);
      u_m.wbyte(d, i == n - 1 ? k : 8, ack);
    end
    if (k == 8)
      q.push_back({a + 16'(n - 1), d});
    u_m.stop();
  endtask
  always @(negedge CLK)
  begin
    cyc <= cyc + 1;
    if (WR_STROBE === 1'b1)
      chk({WR_ADDR, WR_DATA}, q.size() ? q.pop_front() : 24'hFFFFFF);
    if (cyc == 40000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge CLK);
    chk({STANDBY, SDA_OE}, 2'b10);
    ARST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    for (int n = 1; n <= 2; n++)
    begin
      wr(n, 8);
      chk({WRITE_BUSY, STANDBY}, 2'b10);
      sel({`TYPE_ID, `CHIP_ENABLE, 1'b0}, 1'b1);
      u_m.stop();
      for (int i = 0; i < 3000 && WRITE_BUSY !== 1'b0; i++)
        @(posedge CLK);
      repeat (3) @(posedge CLK);
      chk({WRITE_BUSY, STANDBY}, 2'b01);
      chk(ADDR_COUNTER, a + 16'(n));
      $display("write %0d done", n);
    end
    for (int i = 0; i < 2; i++)
    begin
      sel(i ? 8'h52 : 8'hA4, 1'b1);
      u_m.stop();
      chk(STANDBY, 1'b1);
      wr(i, 4);
      chk(WRITE_BUSY, 1'b0);
    end
    $display("refusals done");
    sel({`TYPE_ID, `CHIP_ENABLE, 1'b1}, 1'b0);
    chk(READ_SELECTED, 1'b1);
    u_m.wbyte(8'hFF, 8, ack);
    u_m.stop();
    chk(STANDBY, 1'b1);
    $display("read select done");
    @(posedge CLK);
    ARST_N <= 1'b0;
    sel({`TYPE_ID, `CHIP_ENABLE, 1'b0}, 1'b1);
    u_m.stop();
    chk({STANDBY, SDA_OE}, 2'b10);
    chk(q.size(), 0);
    $display("reset done");
    summarize();
  end
endmodule // tb_top
